//--- rtl/cmb_pkg.sv
// Purpose: constants for the receive mask and buffer status block
// Assumes: 16-bit register port, word-indexed register addresses
// Notes: offsets are register indices on the plain port
package cmb_pkg;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   // register indices
   localparam logic [3:0] OFS_MASK_SEL = 4'h0;
   localparam logic [3:0] OFS_M0_STD = 4'h1;
   localparam logic [3:0] OFS_M0_EXT = 4'h2;
   localparam logic [3:0] OFS_M1_STD = 4'h3;
   localparam logic [3:0] OFS_M1_EXT = 4'h4;
   localparam logic [3:0] OFS_M2_STD = 4'h5;
   localparam logic [3:0] OFS_M2_EXT = 4'h6;
   localparam logic [3:0] OFS_FULL_LO = 4'h7;
   localparam logic [3:0] OFS_FULL_HI = 4'h8;
   localparam logic [3:0] OFS_OVF_LO = 4'h9;
   localparam logic [3:0] OFS_OVF_HI = 4'ha;
   // reset values
   localparam logic [15:0] RST_MASK_SEL = 16'h0000;
   localparam logic [15:0] RST_MASK_WORD = 16'h0000;
   localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
   // standard word layout
   localparam int unsigned STD_HI = 15;
   localparam int unsigned STD_LO = 5;
   localparam int unsigned IDTYPE_BIT = 3;
   localparam logic [15:0] STD_WORD_MASK = 16'hffeb; // bits 4 and 2 unimpl
   // mask source codes
   localparam logic [1:0] SRC_SET0 = 2'h0;
   localparam logic [1:0] SRC_SET1 = 2'h1;
   localparam logic [1:0] SRC_SET2 = 2'h2;
   localparam logic [1:0] SRC_NONE = 2'h3;
   localparam int unsigned FIRST_FILTER = 8;
   localparam int unsigned NUM_SEL = 8;
   localparam int unsigned NUM_BUF = 32;
endpackage

//--- rtl/cmb_match.sv
// Purpose: one acceptance compare of a frame id against a filter
// Assumes: mask words already selected by the caller
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cmb_match (
   // frame
   input wire logic [10:0] frame_std_id,
   input wire logic [17:0] frame_ext_id,
   input wire logic frame_ext,
   // filter
   input wire logic [10:0] filt_std_id,
   input wire logic [17:0] filt_ext_id,
   input wire logic filter_extended_select,
   // mask
   input wire logic [10:0] mask_std_id,
   input wire logic [17:0] mask_ext_id,
   input wire logic id_type_match_control,
   // result
   output logic hit
);
   logic std_ok;
   logic ext_ok;
   // only bits whose mask is 1 take part in the compare
   always_comb begin
      std_ok = ((frame_std_id ^ filt_std_id) & mask_std_id)
         == 11'h000;
      ext_ok = ((frame_ext_id ^ filt_ext_id) & mask_ext_id)
         == 18'h00000;
      if (id_type_match_control) begin
         // type must agree with the filter's extended select
         hit = (frame_ext == filter_extended_select) && std_ok &&
            (!frame_ext || ext_ok);
      end else begin
         // either type accepted: standard id alone, or full id
         hit = std_ok && (!frame_ext || ext_ok);
      end
   end
endmodule
`default_nettype wire

//--- rtl/cmb_rx_mask_status.sv
// Purpose: mask selection for filters 8-15, mask sets, rx buffer flags
// Assumes: frame store requests arrive as one-cycle pulses with a buffer
// Notes: registers read one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module cmb_rx_mask_status #(
   parameter int unsigned NUM_BUFFERS = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // acceptance query for one of filters 8-15
   input wire logic [2:0] filter_index,
   input wire logic [10:0] frame_std_id,
   input wire logic [17:0] frame_ext_id,
   input wire logic frame_ext,
   input wire logic [10:0] filt_std_id,
   input wire logic [17:0] filt_ext_id,
   input wire logic filter_extended_select,
   output logic filter_hit,
   // buffer store event
   input wire logic store_valid,
   input wire logic [4:0] store_buffer,
   // flag view
   output logic [31:0] rx_buffer_full_flag,
   output logic [31:0] rx_buffer_overflow_flag
);
   // flags live in two fixed 16-bit words; refuse any other count
   if (NUM_BUFFERS != cmb_pkg::NUM_BUF) begin : g_bad_buffers
      $error("NUM_BUFFERS must be 32");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [15:0] sel_reg, sel_next;
   logic [15:0] msid_reg [3];
   logic [15:0] msid_next [3];
   logic [15:0] meid_reg [3];
   logic [15:0] meid_next [3];
   logic [31:0] full_reg, full_next;
   logic [31:0] ovf_reg, ovf_next;
   logic [15:0] rdata_reg, rdata_next;

   // source selector field of one filter
   function automatic logic [1:0] src_of(input logic [15:0] sel,
                                         input logic [2:0] idx);
      src_of = sel[{idx, 1'b0} +: 2];
   endfunction

   // clear-on-zero write, with set winning over clear
   function automatic logic [15:0] w0c(input logic [15:0] cur,
                                       input logic [15:0] wd,
                                       input logic wr,
                                       input logic [15:0] set);
      w0c = (wr ? (cur & wd) : cur) | set;
   endfunction

   // ----------------------------------------
   // acceptance path
   // ----------------------------------------
   logic [1:0] src;
   logic [1:0] set_idx;
   logic [10:0] use_msid;
   logic [17:0] use_meid;
   logic use_type;

   // pick mask set; no mask means every bit is compared
   always_comb begin
      src = src_of(sel_reg, filter_index);
      set_idx = 2'h0;
      use_msid = 11'h7ff;
      use_meid = 18'h3ffff;
      use_type = 1'b0;
      unique case (src)
         cmb_pkg::SRC_SET0: set_idx = 2'h0;
         cmb_pkg::SRC_SET1: set_idx = 2'h1;
         cmb_pkg::SRC_SET2: set_idx = 2'h2;
         cmb_pkg::SRC_NONE: set_idx = 2'h3;
      endcase
      if (set_idx != 2'h3) begin
         use_msid = msid_reg[set_idx][cmb_pkg::STD_HI:cmb_pkg::STD_LO];
         use_meid = {msid_reg[set_idx][1:0], meid_reg[set_idx]};
         use_type = msid_reg[set_idx][cmb_pkg::IDTYPE_BIT];
      end
   end

   // with no mask the type control is off, so either type may hit
   cmb_match u_match (
      .frame_std_id(frame_std_id),
      .frame_ext_id(frame_ext_id),
      .frame_ext(frame_ext),
      .filt_std_id(filt_std_id),
      .filt_ext_id(filt_ext_id),
      .filter_extended_select(filter_extended_select),
      .mask_std_id(use_msid),
      .mask_ext_id(use_meid),
      .id_type_match_control(use_type),
      .hit(filter_hit)
   );

   // ----------------------------------------
   // register writes and flag updates
   // ----------------------------------------
   logic [31:0] set_full;
   logic [31:0] set_ovf;
   logic wr_fl, wr_fh, wr_ol, wr_oh;

   always_comb begin
      sel_next = sel_reg;
      msid_next = msid_reg;
      meid_next = meid_reg;
      set_full = 32'h0000_0000;
      set_ovf = 32'h0000_0000;
      if (store_valid) begin
         set_full[store_buffer] = 1'b1;
         set_ovf[store_buffer] = full_reg[store_buffer];
      end
      wr_fl = reg_wr && (reg_addr == cmb_pkg::OFS_FULL_LO);
      wr_fh = reg_wr && (reg_addr == cmb_pkg::OFS_FULL_HI);
      wr_ol = reg_wr && (reg_addr == cmb_pkg::OFS_OVF_LO);
      wr_oh = reg_wr && (reg_addr == cmb_pkg::OFS_OVF_HI);
      if (reg_wr) begin
         unique case (reg_addr)
            cmb_pkg::OFS_MASK_SEL: sel_next = reg_wdata;
            cmb_pkg::OFS_M0_STD:
               msid_next[0] = reg_wdata & cmb_pkg::STD_WORD_MASK;
            cmb_pkg::OFS_M0_EXT: meid_next[0] = reg_wdata;
            cmb_pkg::OFS_M1_STD:
               msid_next[1] = reg_wdata & cmb_pkg::STD_WORD_MASK;
            cmb_pkg::OFS_M1_EXT: meid_next[1] = reg_wdata;
            cmb_pkg::OFS_M2_STD:
               msid_next[2] = reg_wdata & cmb_pkg::STD_WORD_MASK;
            cmb_pkg::OFS_M2_EXT: meid_next[2] = reg_wdata;
            default: ; // flags and unmapped handled below
         endcase
      end
      // a store in the clearing cycle still leaves the flag set
      full_next = {w0c(full_reg[31:16], reg_wdata, wr_fh, set_full[31:16]),
         w0c(full_reg[15:0], reg_wdata, wr_fl, set_full[15:0])};
      ovf_next = {w0c(ovf_reg[31:16], reg_wdata, wr_oh, set_ovf[31:16]),
         w0c(ovf_reg[15:0], reg_wdata, wr_ol, set_ovf[15:0])};
   end

   // read mux; unmapped indices read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd) begin
         unique case (reg_addr)
            cmb_pkg::OFS_MASK_SEL: rdata_next = sel_reg;
            cmb_pkg::OFS_M0_STD: rdata_next = msid_reg[0];
            cmb_pkg::OFS_M0_EXT: rdata_next = meid_reg[0];
            cmb_pkg::OFS_M1_STD: rdata_next = msid_reg[1];
            cmb_pkg::OFS_M1_EXT: rdata_next = meid_reg[1];
            cmb_pkg::OFS_M2_STD: rdata_next = msid_reg[2];
            cmb_pkg::OFS_M2_EXT: rdata_next = meid_reg[2];
            cmb_pkg::OFS_FULL_LO: rdata_next = full_reg[15:0];
            cmb_pkg::OFS_FULL_HI: rdata_next = full_reg[31:16];
            cmb_pkg::OFS_OVF_LO: rdata_next = ovf_reg[15:0];
            cmb_pkg::OFS_OVF_HI: rdata_next = ovf_reg[31:16];
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // registers; ce low freezes everything
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sel_reg <= cmb_pkg::RST_MASK_SEL;
         for (int i = 0; i < 3; i++) begin
            msid_reg[i] <= cmb_pkg::RST_MASK_WORD;
            meid_reg[i] <= cmb_pkg::RST_MASK_WORD;
         end
         full_reg <= cmb_pkg::RST_FLAGS;
         ovf_reg <= cmb_pkg::RST_FLAGS;
         rdata_reg <= 16'h0000;
      end else if (ce) begin
         sel_reg <= sel_next;
         msid_reg <= msid_next;
         meid_reg <= meid_next;
         full_reg <= full_next;
         ovf_reg <= ovf_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign rx_buffer_full_flag = full_reg;
   assign rx_buffer_overflow_flag = ovf_reg;
endmodule
`default_nettype wire

//--- testbench/cmb_can_node.sv
// Purpose: bus node model feeding frame ids and store events
// Assumes: one store event per call
// Notes: ids are levels, held until the next frame
`timescale 1ns/1ps
`default_nettype none
module cmb_can_node (
   // clock
   input wire logic clk,
   // frame and store event
   output logic [10:0] frame_std_id,
   output logic [17:0] frame_ext_id,
   output logic frame_ext,
   output logic store_valid,
   output logic [4:0] store_buffer
);
   // ----
   // traffic
   // ----
   initial {frame_std_id, frame_ext_id, frame_ext} = '0;
   initial {store_valid, store_buffer} = '0;
   // a new id lands on an edge so hit settles a full cycle
   task automatic send(input logic [10:0] s, input logic [17:0] e,
      input logic x);
      @(posedge clk);
      {frame_std_id, frame_ext_id, frame_ext} <= {s, e, x};
   endtask
   // one-cycle pulse; calls never overlap
   task automatic store(input logic [4:0] b);
      @(posedge clk);
      {store_buffer, store_valid} <= {b, 1'b1};
      @(posedge clk);
      store_valid <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/cmb_chk_sva.sv
// Purpose: port checker for rx masks and buffer flags
// Assumes: bound to the block's top module
// Notes: last-cycle copies tie reads and writes to the flags
`timescale 1ns/1ps
`default_nettype none
module cmb_chk #(
   parameter int unsigned NUM_BUFFERS = 32
) (
   // clock, reset, register port
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // store event and flags
   input wire logic store_valid,
   input wire logic [4:0] store_buffer,
   input wire logic [31:0] rx_buffer_full_flag,
   input wire logic [31:0] rx_buffer_overflow_flag
);
   // ----
   // checks
   // ----
   logic [31:0] full_q, ovf_q;
   logic [15:0] wd_q;
   logic full_up, ovf_up, rd_fl, rd_oh, rd_std, wr_fl;
   always_ff @(posedge clk) begin
      full_q <= rx_buffer_full_flag;
      ovf_q <= rx_buffer_overflow_flag;
      wd_q <= reg_wdata;
   end
   // decoded events keep the properties short
   assign full_up = |(rx_buffer_full_flag & ~full_q);
   assign ovf_up = |(rx_buffer_overflow_flag & ~ovf_q);
   assign rd_fl = reg_rd && ce && reg_addr == cmb_pkg::OFS_FULL_LO;
   assign rd_oh = reg_rd && ce && reg_addr == cmb_pkg::OFS_OVF_HI;
   assign rd_std = reg_rd && ce && reg_addr inside {cmb_pkg::OFS_M0_STD,
      cmb_pkg::OFS_M1_STD, cmb_pkg::OFS_M2_STD};
   assign wr_fl = reg_wr && ce && !store_valid &&
      reg_addr == cmb_pkg::OFS_FULL_LO;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_full_set: assert property (store_valid && ce |=>
      rx_buffer_full_flag[$past(store_buffer)]) else $error("full not set");
   chk_ovf_set: assert property (store_valid && ce &&
      rx_buffer_full_flag[store_buffer] |=>
      rx_buffer_overflow_flag[$past(store_buffer)]) else $error("ovf not set");
   chk_full_cause: assert property (full_up |-> $past(store_valid))
      else $error("full rose without store");
   chk_ovf_cause: assert property (ovf_up |-> $past(store_valid))
      else $error("ovf rose without store");
   chk_rd_full: assert property (rd_fl |=> reg_rdata == full_q[15:0])
      else $error("full low read wrong");
   chk_rd_ovf: assert property (rd_oh |=> reg_rdata == ovf_q[31:16])
      else $error("ovf high read wrong");
   chk_std_gap: assert property (rd_std |=>
      (reg_rdata & ~cmb_pkg::STD_WORD_MASK) == 16'h0000) else $error("gap");
   chk_w1_keep: assert property (wr_fl |=>
      rx_buffer_full_flag[15:0] == (full_q[15:0] & wd_q)) else $error("clr");
   cov_ovf: cover property (store_valid && rx_buffer_full_flag[store_buffer]);
   cov_clr: cover property (wr_fl);
   cov_rd: cover property (rd_oh);
endmodule
bind cmb_rx_mask_status cmb_chk #(.NUM_BUFFERS(NUM_BUFFERS)) u_chk (.clk,
   .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .store_valid, .store_buffer, .rx_buffer_full_flag,
   .rx_buffer_overflow_flag);
`default_nettype wire

//--- testbench/cmb_rx_mask_status_tb.sv
// Purpose: self-checking bench for rx masks and buffer flags
// Assumes: ce held high except in the hold test, frames from the node model
// Notes: hit patterns are per filter 8..15, bit 0 first
`timescale 1ns/1ps
`default_nettype none
module cmb_rx_mask_status_tb;
   logic clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ce = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [2:0] filter_index = 3'h0;
   logic [10:0] frame_std_id, filt_std_id = 11'h000;
   logic [17:0] frame_ext_id, filt_ext_id = 18'h00000;
   logic frame_ext, fes = 1'b0, filter_hit, store_valid;
   logic [4:0] store_buffer;
   logic [31:0] full, ovf;
   int err_total = 0, checks = 0;
   // ----
   // harness
   // ----
   initial forever #12.5 clk = ~clk;
   cmb_rx_mask_status uut (.clk, .nrst, .ce, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .filter_index, .frame_std_id,
      .frame_ext_id, .frame_ext, .filt_std_id, .filt_ext_id,
      .filter_extended_select(fes), .filter_hit, .store_valid,
      .store_buffer, .rx_buffer_full_flag(full),
      .rx_buffer_overflow_flag(ovf));
   cmb_can_node node (.clk, .frame_std_id, .frame_ext_id, .frame_ext,
      .store_valid, .store_buffer);
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   // one-cycle strobes with a free edge between accesses
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rc(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk({16'h0000, reg_rdata}, {16'h0000, e});
   endtask
   // hit is combinational, so it is sampled a whole cycle after the index
   task automatic sweep(input logic [7:0] p);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         filter_index <= 3'(i);
         @(posedge clk);
         chk({31'h0, filter_hit}, {31'h0, p[i]});
      end
   endtask
   task automatic t_regs();
      for (int a = 0; a < 12; a++) rc(4'(a), 16'h0000);
      wr(cmb_pkg::OFS_M0_STD, 16'hffff);
      rc(cmb_pkg::OFS_M0_STD, 16'hffeb);
      wr(4'hb, 16'hffff);
      rc(4'hb, 16'h0000);
   endtask
   task automatic t_accept();
      wr(cmb_pkg::OFS_M0_STD, 16'h0000);
      wr(cmb_pkg::OFS_M1_STD, 16'hffe0);
      wr(cmb_pkg::OFS_M1_EXT, 16'h0001);
      wr(cmb_pkg::OFS_M2_STD, 16'h0008);
      wr(cmb_pkg::OFS_MASK_SEL, 16'h1be4);
      rc(cmb_pkg::OFS_M1_EXT, 16'h0001);
      rc(cmb_pkg::OFS_MASK_SEL, 16'h1be4);
      node.send(11'h122, 18'h00000, 1'b0);
      {filt_std_id, fes} <= {11'h123, 1'b1};
      sweep(8'h81);
      node.send(11'h123, 18'h00001, 1'b1);
      sweep(8'ha5);
      node.send(11'h122, 18'h00000, 1'b0);
      fes <= 1'b0;
      sweep(8'ha5);
   endtask
   task automatic t_flags();
      node.store(5'd3);
      node.store(5'd20);
      rc(cmb_pkg::OFS_FULL_LO, 16'h0008);
      rc(cmb_pkg::OFS_FULL_HI, 16'h0010);
      rc(cmb_pkg::OFS_OVF_LO, 16'h0000);
      node.store(5'd3);
      node.store(5'd20);
      rc(cmb_pkg::OFS_OVF_HI, 16'h0010);
      wr(cmb_pkg::OFS_FULL_LO, 16'hfff7);
      wr(cmb_pkg::OFS_OVF_HI, 16'hffff);
      chk(full, 32'h0010_0000);
      chk(ovf, 32'h0010_0008);
   endtask
   // a store while frozen is lost; a mid-run reset clears flags and the mask selector
   task automatic t_hold();
      @(posedge clk);
      ce <= 1'b0;
      node.store(5'd7);
      ce <= 1'b1;
      rc(cmb_pkg::OFS_FULL_LO, 16'h0000);
      chk(full, 32'h0010_0000);
      @(posedge clk);
      nrst <= 1'b0;
      @(posedge clk);
      nrst <= 1'b1;
      #1 chk(full, 32'h0000_0000);
      chk(ovf, 32'h0000_0000);
      rc(cmb_pkg::OFS_MASK_SEL, 16'h0000);
   endtask
   task automatic end_sim();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      t_regs();
      t_accept();
      t_flags();
      t_hold();
      end_sim();
   end
   // the scenarios need about 130 cycles; this 4000-cycle limit is some thirty times that
   initial begin
      #100000;
      err_total++;
      end_sim();
   end
endmodule
`default_nettype wire
